// ===== src/eio_bank_decode.v
// Window decoder for one external I/O bank.
// Assumes a control word as held by the top level; purely combinational.
`timescale 1ns/1ps
`include "eio_regs.vh"

module eio_bank_decode
(
    input wire [31:0] ctrl_i, // bank control word
    input wire [31:0] addr_i, // internal byte address
    output wire hit_o // address falls in an enabled bank
);
    wire [2:0] size_code;
    wire [31:0] start;
    wire [31:0] mask;
    wire size_ok;
    wire width_ok;

    assign size_code = ctrl_i[`EIO_SIZE_MSB:`EIO_SIZE_LSB];
    // Start address is the base pointer moved up by the fixed bank shift.
    assign start = {1'b0, ctrl_i[`EIO_BASE_MSB:`EIO_BASE_LSB],
                    18'h00000};
    assign mask = (`EIO_SIZE_256K << size_code) - 32'h00000001;
    // Reserved size codes never claim a window, so a slip cannot alias.
    assign size_ok = (size_code <= `EIO_SIZE_MAX_CODE);
    assign width_ok = (ctrl_i[`EIO_WD_MSB:`EIO_WD_LSB] != `EIO_WD_OFF) &&
                      (ctrl_i[`EIO_WD_MSB:`EIO_WD_LSB] != 2'h3);
    assign hit_o = size_ok && width_ok &&
                   ((addr_i & ~mask) == (start & ~mask));
endmodule

// ===== src/eio_regs.vh
// Register map, field positions and timing codes of the external I/O banks.
// Included by the bank decoder and by the top level; holds definitions only.
`ifndef EIO_REGS_VH
`define EIO_REGS_VH

`define EIO_BANK0_ADDR 32'hFFF01018
`define EIO_BANK1_ADDR 32'hFFF0101C
`define EIO_BANK2_ADDR 32'hFFF01020
`define EIO_BANK3_ADDR 32'hFFF01024
`define EIO_BANK_CTRL_RESET 32'h00000000
`define EIO_NUM_BANKS 4

`define EIO_BASE_MSB 31
`define EIO_BASE_LSB 19
`define EIO_BASE_SHIFT 18
`define EIO_SIZE_MSB 18
`define EIO_SIZE_LSB 16
`define EIO_ALIGN_BIT 15
`define EIO_ACC_MSB 14
`define EIO_ACC_LSB 11
`define EIO_COH_MSB 10
`define EIO_COH_LSB 8
`define EIO_ACS_MSB 7
`define EIO_ACS_LSB 5
`define EIO_COS_MSB 4
`define EIO_COS_LSB 2
`define EIO_WD_MSB 1
`define EIO_WD_LSB 0

`define EIO_SIZE_256K 32'h00040000
`define EIO_SIZE_MAX_CODE 3'h5
`define EIO_WD_OFF 2'h0
`define EIO_WD_8 2'h1
`define EIO_WD_16 2'h2
`define EIO_ACC_LINEAR_MAX 4'h7
`define EIO_ACC_STEP_OFFSET 5'h07

`endif

// ===== src/eio_top.v
// External I/O bank controller: four control registers on APB, a simple
// internal access port, and the chip-select and strobe sequencer.
// Assumes one 50 MHz clock; the external device samples on these outputs.
//
// Contract
// - Block does its own chip-select decode and strobe timing, no glue.
// - Four banks, one control register each, all reset to zero.
// - Bank start address is the base pointer shifted left by 18.
// - Bank claims only addresses inside base plus size window; the code matches the size-aligned window that holds the start address.
// - Size codes 0..5 give 256K to 8M bytes; 6 and 7 reserved.
// - Byte-align bit puts internal byte address straight on A20..A0.
// - With byte-align set, the bus width field is ignored for address.
// - Width 00 disables bank, 01 is 8-bit, 10 is 16-bit, 11 reserved.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "eio_regs.vh"

module eio_top
(
    input wire clk_i, // 50 MHz clock
    input wire rst_n_i, // async reset, active low
    input wire psel_i, // APB select
    input wire penable_i, // APB enable
    input wire pwrite_i, // APB direction
    input wire [31:0] paddr_i, // APB byte address
    input wire [31:0] pwdata_i, // APB write data
    output reg [31:0] prdata_o, // APB read data
    output reg pready_o, // APB ready
    output reg pslverr_o, // APB unmapped address
    input wire req_valid_i, // internal access request
    input wire req_write_i, // 1 write, 0 read
    input wire [31:0] req_addr_i, // internal byte address
    input wire [1:0] req_be_i, // byte lanes of the access
    input wire [15:0] req_wdata_i, // write data
    output reg req_done_o, // access finished pulse
    output reg req_err_o, // no bank claimed the address
    output reg [15:0] req_rdata_o, // read data
    output reg busy_o, // sequencer busy, requests ignored
    output reg [20:0] ext_addr_o, // external address A20..A0
    output reg [3:0] external_chip_select_n_o, // bank selects
    output reg output_enable_n_o, // read strobe
    output reg [1:0] write_byte_enable_n_o, // write strobes
    output reg [15:0] ext_data_o, // external data out
    output reg ext_data_oe_n_o, // data drive enable, low drives
    input wire [15:0] ext_data_i // external data in
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_CSSU = 3'h2;
    localparam ST_ACC = 3'h3;
    localparam ST_HOLD = 3'h4;

    reg [31:0] ctrl_q [0:3];
    reg [2:0] state_q;
    reg [4:0] cnt_q;
    reg [1:0] bank_q;
    reg write_q;
    reg [1:0] be_q;
    wire [3:0] hit;
    wire [31:0] sel_ctrl;
    wire [4:0] acc_cycles;
    wire [3:0] acc_code;
    wire apb_access;
    wire [2:0] reg_idx;
    reg [1:0] hit_idx;
    reg hit_any;
    integer i;

    genvar g;
    generate
        for (g = 0; g < `EIO_NUM_BANKS; g = g + 1)
        begin : g_bank
            eio_bank_decode u_dec
            (
                .ctrl_i(ctrl_q[g]),
                .addr_i(req_addr_i),
                .hit_o(hit[g])
            );
        end
    endgenerate

    // Lowest-numbered bank wins if windows were programmed to overlap.
    always @*
    begin
        hit_any = 1'b0;
        hit_idx = 2'h0;
        for (i = 3; i >= 0; i = i - 1)
        begin
            if (hit[i])
            begin
                hit_any = 1'b1;
                hit_idx = i[1:0];
            end
        end
    end

    assign apb_access = psel_i && penable_i && !pready_o;
    assign reg_idx = (paddr_i == `EIO_BANK0_ADDR) ? 3'h0 :
                     (paddr_i == `EIO_BANK1_ADDR) ? 3'h1 :
                     (paddr_i == `EIO_BANK2_ADDR) ? 3'h2 :
                     (paddr_i == `EIO_BANK3_ADDR) ? 3'h3 : 3'h4;

    // One wait state: ready rises in the second access cycle.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q[0] <= `EIO_BANK_CTRL_RESET;
            ctrl_q[1] <= `EIO_BANK_CTRL_RESET;
            ctrl_q[2] <= `EIO_BANK_CTRL_RESET;
            ctrl_q[3] <= `EIO_BANK_CTRL_RESET;
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= apb_access;
            pslverr_o <= apb_access && reg_idx[2];
            prdata_o <= 32'h00000000;
            if (apb_access && !reg_idx[2])
            begin
                if (pwrite_i)
                    ctrl_q[reg_idx[1:0]] <= pwdata_i;
                else
                    prdata_o <= ctrl_q[reg_idx[1:0]];
            end
        end
    end

    assign sel_ctrl = ctrl_q[bank_q];
    // Codes 1..7 count directly; above that each step adds two cycles.
    // Reserved code zero is run as one cycle rather than a stuck strobe.
    assign acc_code = sel_ctrl[`EIO_ACC_MSB:`EIO_ACC_LSB];
    assign acc_cycles = (acc_code == 4'h0) ? 5'h01 :
                        (acc_code <= `EIO_ACC_LINEAR_MAX) ? {1'b0, acc_code} :
                        ({acc_code, 1'b0} - `EIO_ACC_STEP_OFFSET);

    // External address according to alignment and data width.
    function [20:0] ext_address;
        input [31:0] ctrl;
        input [31:0] addr;
        begin
            if (ctrl[`EIO_ALIGN_BIT])
                ext_address = addr[20:0];
            else if (ctrl[`EIO_WD_MSB:`EIO_WD_LSB] == `EIO_WD_16)
                ext_address = addr[21:1];
            else
                ext_address = addr[20:0];
        end
    endfunction

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            bank_q <= 2'h0;
            write_q <= 1'b0;
            be_q <= 2'h0;
            req_done_o <= 1'b0;
            req_err_o <= 1'b0;
            req_rdata_o <= 16'h0000;
            busy_o <= 1'b0;
            ext_addr_o <= 21'h000000;
            external_chip_select_n_o <= 4'hF;
            output_enable_n_o <= 1'b1;
            write_byte_enable_n_o <= 2'h3;
            ext_data_o <= 16'h0000;
            ext_data_oe_n_o <= 1'b1;
        end
        else
        begin
            req_done_o <= 1'b0;
            req_err_o <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (req_valid_i && !hit_any)
                    begin
                        req_done_o <= 1'b1;
                        req_err_o <= 1'b1;
                    end
                    else if (req_valid_i)
                    begin
                        bank_q <= hit_idx;
                        write_q <= req_write_i;
                        // An 8-bit bank only ever uses the low lane.
                        be_q <= (ctrl_q[hit_idx][`EIO_WD_MSB:`EIO_WD_LSB] ==
                                 `EIO_WD_8) ? 2'h1 : req_be_i;
                        ext_addr_o <= ext_address(ctrl_q[hit_idx],
                                                  req_addr_i);
                        ext_data_o <= req_wdata_i;
                        ext_data_oe_n_o <= !req_write_i;
                        cnt_q <= {2'h0, ctrl_q[hit_idx]
                                  [`EIO_ACS_MSB:`EIO_ACS_LSB]};
                        busy_o <= 1'b1;
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_q == 5'h00)
                    begin
                        external_chip_select_n_o <= ~(4'h1 << bank_q);
                        cnt_q <= {2'h0, sel_ctrl[`EIO_COS_MSB:`EIO_COS_LSB]};
                        state_q <= ST_CSSU;
                    end
                    else
                        cnt_q <= cnt_q - 5'h01;
                end
                ST_CSSU:
                begin
                    if (cnt_q == 5'h00)
                    begin
                        output_enable_n_o <= write_q;
                        write_byte_enable_n_o <= write_q ? ~be_q : 2'h3;
                        cnt_q <= acc_cycles - 5'h01;
                        state_q <= ST_ACC;
                    end
                    else
                        cnt_q <= cnt_q - 5'h01;
                end
                ST_ACC:
                begin
                    if (cnt_q == 5'h00)
                    begin
                        output_enable_n_o <= 1'b1;
                        write_byte_enable_n_o <= 2'h3;
                        req_rdata_o <= ext_data_i;
                        cnt_q <= {2'h0, sel_ctrl[`EIO_COH_MSB:`EIO_COH_LSB]};
                        state_q <= ST_HOLD;
                    end
                    else
                        cnt_q <= cnt_q - 5'h01;
                end
                ST_HOLD:
                begin
                    if (cnt_q == 5'h00)
                    begin
                        external_chip_select_n_o <= 4'hF;
                        ext_data_oe_n_o <= 1'b1;
                        req_done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else
                        cnt_q <= cnt_q - 5'h01;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== tb/eio_ext_sram.sv
// Behavioural 16-bit static memory on the external I/O bus.
// Assumes active-low select and strobes; data sampled by the block.
`timescale 1ns/1ps
module eio_ext_sram
(
    input wire clk_i, // clock
    input wire cs_n_i, // any bank selected, low
    input wire oe_n_i, // read strobe
    input wire [1:0] we_n_i, // write strobes
    input wire [20:0] addr_i, // address
    input wire [15:0] data_i, // write data
    output wire [15:0] data_o // read data
);
    reg [15:0] mem [0:255];
    reg [15:0] last = 16'h0;
    wire rd = !cs_n_i && !oe_n_i;
    // Off the bus the lines show the inverse of the last word, never a copy.
    assign data_o = rd ? mem[addr_i[7:0]] : ~last;
    always @(posedge clk_i)
    begin
        if (rd)
            last <= mem[addr_i[7:0]];
        if (!cs_n_i && !we_n_i[0])
            mem[addr_i[7:0]][7:0] <= data_i[7:0];
        if (!cs_n_i && !we_n_i[1])
            mem[addr_i[7:0]][15:8] <= data_i[15:8];
    end
endmodule

// ===== tb/eio_top_asserts.sv
// Checker for eio_top: APB answers, bank selects and strobes.
// Bound to eio_top by the bench; sees only the ports of that module.
`timescale 1ns/1ps
module eio_top_asserts
(
    input wire clk_i, // clock
    input wire rst_n_i, // reset
    input wire psel_i, // select
    input wire penable_i, // enable
    input wire [31:0] paddr_i, // address
    input wire [31:0] prdata_o, // read data
    input wire pready_o, // ready
    input wire pslverr_o, // error
    input wire req_done_o, // done
    input wire req_err_o, // miss
    input wire busy_o, // busy
    input wire [3:0] external_chip_select_n_o, // selects
    input wire output_enable_n_o, // read strobe
    input wire [1:0] write_byte_enable_n_o, // write strobes
    input wire ext_data_oe_n_o // data drive
);
    wire [31:0] off = paddr_i - 32'hFFF01018;
    wire mapped = off < 32'h10 && off[1:0] == 2'h0;
    wire strobe = !output_enable_n_o || !(&write_byte_enable_n_o);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; pready_o |=> !pready_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_map; pready_o |-> pslverr_o == !mapped; endproperty
    a_map: assert property (p_map) else $error("bad decode");
    property p_zero; pslverr_o |-> prdata_o == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("data on error");
    property p_one; strobe |-> $onehot(~external_chip_select_n_o); endproperty
    a_one: assert property (p_one) else $error("select wrong");
    property p_miss; req_err_o |-> req_done_o && &external_chip_select_n_o;
    endproperty
    a_miss: assert property (p_miss) else $error("miss selected");
    property p_excl; !output_enable_n_o |-> &write_byte_enable_n_o &&
        ext_data_oe_n_o; endproperty
    a_excl: assert property (p_excl) else $error("strobe clash");
    property p_done; req_done_o |-> !busy_o && !strobe ##1 !req_done_o;
    endproperty
    a_done: assert property (p_done) else $error("bad done");
endmodule

// ===== tb/external_io_bank_control_bench.sv
// Self-checking bench for eio_top with a behavioural memory on its bus.
// Assumes eio_top_asserts and eio_ext_sram are compiled before this file.
`timescale 1ns/1ps
module external_io_bank_control_bench;
    logic clk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
    logic pwrite_i = 1'h0, req_valid_i = 1'h0, req_write_i = 1'h0;
    logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, req_addr_i = 32'h0;
    logic [31:0] seed = 32'hAB9AE2F8, a, sz;
    logic [1:0] req_be_i = 2'h3;
    logic [15:0] req_wdata_i = 16'h0;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, req_done_o, req_err_o, busy_o;
    wire output_enable_n_o, ext_data_oe_n_o;
    wire [15:0] req_rdata_o, ext_data_o, ext_data_i;
    wire [20:0] ext_addr_o;
    wire [3:0] external_chip_select_n_o;
    wire [1:0] write_byte_enable_n_o;
    logic [32:0] aq [$];
    logic [47:0] eq [$];
    logic [47:0] ee;
    logic [3:0] ccs = 4'hF;
    logic [20:0] ca = 21'h0;
    logic [4:0] cn = 5'h0;
    int mismatches = 0, comparisons = 0, n;
    int codes [4] = '{1, 7, 8, 15};
    localparam [47:0] miss_e = {2'h1, 4'hF, 26'h0, 16'h0};
    eio_top DUT (.*);
    // An undriven data bus shows the inverse, so a missing drive is caught.
    eio_ext_sram u_mem (.clk_i, .cs_n_i(&external_chip_select_n_o),
        .oe_n_i(output_enable_n_o), .we_n_i(write_byte_enable_n_o),
        .addr_i(ext_addr_o),
        .data_i(ext_data_oe_n_o ? ~ext_data_o : ext_data_o),
        .data_o(ext_data_i));
    initial forever #10 clk_i = ~clk_i;
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic [31:0] ctl(input [12:0] b, input [2:0] s, input al,
        input [3:0] ac, input [1:0] wd);
        ctl = {b, s, al, ac, seed[8:0], wd};
    endfunction
    function automatic [47:0] hit(input [1:0] b, input [3:0] c,
        input [20:0] ad, input [16:0] d);
        // Access codes above 7 stretch the strobe to two cycles a step.
        hit = {d[16], 1'h0, ~(4'h1 << b), c > 7 ? 5'(2 * c - 7) : 5'(c), ad,
            d[15:0]};
    endfunction
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input [47:0] e, s);
        comparisons++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic apb(input w, input [31:0] ad, d, input [32:0] e);
        aq.push_back(e);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        for (n = 0; n < 50 && pready_o !== 1'h1; n++)
            @(negedge clk_i);
        if (n >= 50)
        begin
            mismatches++;
            finish_test();
        end
        @(posedge clk_i);
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic cfg(input [1:0] b, input [31:0] v);
        apb(1'h1, 32'hFFF01018 + {b, 2'h0}, v, 33'h0);
        apb(1'h0, 32'hFFF01018 + {b, 2'h0}, 32'h0, {1'h0, v});
    endtask
    task automatic acc(input w, input [31:0] ad, input [15:0] d,
        input [47:0] e);
        eq.push_back(e);
        req_valid_i <= 1'h1;
        req_write_i <= w;
        req_addr_i <= ad;
        req_wdata_i <= d;
        @(posedge clk_i);
        req_valid_i <= 1'h0;
        for (n = 0; n < 100 && req_done_o !== 1'h1; n++)
            @(negedge clk_i);
        if (n >= 100)
        begin
            mismatches++;
            finish_test();
        end
        @(posedge clk_i);
    endtask
    always @(negedge clk_i)
    begin
        if (pready_o === 1'h1)
            check("apb", aq.size() ? aq.pop_front() : 33'bx,
                {pslverr_o, prdata_o});
        if (!output_enable_n_o || !(&write_byte_enable_n_o))
        begin
            cn = cn + 5'h1;
            ca = ext_addr_o;
            ccs = external_chip_select_n_o;
        end
        if (req_done_o === 1'h1)
        begin
            ee = eq.size() ? eq.pop_front() : 48'bx;
            check("access", ee, {ee[47], req_err_o, ccs, cn, ca,
                ee[47] ? req_rdata_o : ee[15:0]});
            cn = 5'h0;
            ca = 21'h0;
            ccs = 4'hF;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'h1;
        for (int i = 0; i < 4; i++)
            apb(1'h0, 32'hFFF01018 + 32'(i * 4), 32'h0, 33'h0);
        apb(1'h1, 32'hFFF01028, 32'hFFFFFFFF, {1'h1, 32'h0});
        apb(1'h0, 32'hFFF01014, 32'h0, {1'h1, 32'h0});
        for (int k = 0; k < 8; k++)
        begin
            cfg(2'h0, ctl(13'h20, k[2:0], 1'h1, 4'h1, 2'h2));
            sz = 32'h40000 << k;
            a = 32'h800000 + sz - 32'h2;
            if (k < 6)
                acc(1'h0, a, 16'h0, hit(2'h0, 4'h1, a[20:0], 17'h0));
            acc(1'h0, 32'h800000 + (k < 6 ? sz : 32'h0), 16'h0, miss_e);
        end
        cfg(2'h0, ctl(13'h20, 3'h0, 1'h1, 4'h1, 2'h2));
        acc(1'h0, 32'h7FFFFE, 16'h0, miss_e);
        acc(1'h0, 32'h800000, 16'h0, hit(2'h0, 4'h1, 21'h0, 17'h0));
        foreach (codes[j])
        begin
            seed = lfsr(seed);
            a = 32'h800000 + {seed[17:1], 1'h0};
            cfg(2'h0, ctl(13'h20, 3'h0, 1'h1, codes[j][3:0], 2'h2));
            acc(1'h1, a, seed[31:16], hit(2'h0, codes[j][3:0], a[20:0],
                17'h0));
            acc(1'h0, a, 16'h0, hit(2'h0, codes[j][3:0], a[20:0],
                {1'h1, seed[31:16]}));
        end
        a = 32'h8ABCDE;
        for (int m = 0; m < 8; m++)
        begin
            cfg(2'h0, ctl(13'h20, 3'h5, m[2], 4'h1, m[1:0]));
            if (m[1:0] == 2'h0 || m[1:0] == 2'h3)
                acc(1'h0, a, 16'h0, miss_e);
            else
                acc(1'h0, a, 16'h0, hit(2'h0, 4'h1, m == 2 ? a[21:1] :
                    a[20:0], 17'h0));
        end
        cfg(2'h0, 32'h0);
        for (int b = 1; b < 4; b++)
        begin
            cfg(b[1:0], ctl({5'h0, b[1:0], 6'h0}, 3'h0, 1'h1, 4'h2, 2'h1));
            acc(1'h0, {6'h0, b[1:0], 24'h4}, 16'h0, hit(b[1:0], 4'h2,
                21'h4, 17'h0));
        end
        finish_test();
    end
endmodule
bind eio_top eio_top_asserts u_chk (.*);
